// [pkg/gpio_pkg.sv]
// Shared constants and carrier types for the general-purpose port.
package gpio_pkg;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_DATA = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_DIR = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_PULL = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_SLEW = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_DRIVE = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_SET = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_CLR = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_TOG = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_KEY_EN = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_KEY_POL = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_KEY_SC = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_PINS = 6'h2C;
  // Key status and control field positions.
  localparam int KSC_MODE_BIT = 0;
  localparam int KSC_IE_BIT = 1;
  localparam int KSC_ACK_BIT = 2;
  localparam int KSC_FLAG_BIT = 3;
  // Reset values.
  localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
    logic [PORT_W-1:0] ibuf;
    logic [PORT_W-1:0] pull_up;
    logic [PORT_W-1:0] pull_down;
    logic [PORT_W-1:0] slew;
    logic [PORT_W-1:0] high_drive;
  } pin_ctrl_t;

  typedef struct packed {
    logic [PORT_W-1:0] en;
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
  } alt_req_t;
endpackage : gpio_pkg

// [logic/gpio_pin_mux.sv]
// Per-pin steering of buffers, pulls and read source for the whole port.
`timescale 1ns/1ps
module gpio_pin_mux #(
  parameter logic [gpio_pkg::PORT_W-1:0] OUT_ONLY = 8'h00
) (
  // Port state.
  input wire logic [gpio_pkg::PORT_W-1:0] i_latch,
  input wire logic [gpio_pkg::PORT_W-1:0] i_dir,
  input wire logic [gpio_pkg::PORT_W-1:0] i_pull_en,
  input wire logic [gpio_pkg::PORT_W-1:0] i_slew_en,
  input wire logic [gpio_pkg::PORT_W-1:0] i_drive_sel,
  input wire logic [gpio_pkg::PORT_W-1:0] i_key_en,
  input wire logic [gpio_pkg::PORT_W-1:0] i_key_pol,
  // Shared functions and pad.
  input wire gpio_pkg::alt_req_t i_alt,
  input wire logic [gpio_pkg::PORT_W-1:0] i_analog,
  input wire logic [gpio_pkg::PORT_W-1:0] i_pin,
  // Results.
  output gpio_pkg::pin_ctrl_t o_ctrl,
  output logic [gpio_pkg::PORT_W-1:0] o_seen,
  output logic [gpio_pkg::PORT_W-1:0] o_rd
);
  import gpio_pkg::*;
  logic [PORT_W-1:0] alt_own;
  logic [PORT_W-1:0] pull_on;

  always_comb begin
    alt_own = i_alt.en & ~i_analog; // R2 R8
    o_ctrl.oe = ~i_analog & ((alt_own & i_alt.oe) | (~alt_own & i_dir)); // R3 R6 R7
    o_ctrl.out = (alt_own & i_alt.out) | (~alt_own & i_latch); // R6
    o_ctrl.ibuf = ~i_analog & ~OUT_ONLY; // R5 R7
    o_seen = i_pin & o_ctrl.ibuf;
    o_rd = (i_dir & i_latch) | (~i_dir & o_seen); // R4 R7
    pull_on = i_pull_en & ~o_ctrl.oe & ~i_analog; // R10 R13
    o_ctrl.pull_down = pull_on & i_key_en & i_key_pol; // R26
    o_ctrl.pull_up = pull_on & ~(i_key_en & i_key_pol); // R26
    o_ctrl.slew = i_slew_en & o_ctrl.oe; // R11 R13
    o_ctrl.high_drive = i_drive_sel & o_ctrl.oe; // R12 R13
  end
endmodule : gpio_pin_mux

// [logic/key_irq_unit.sv]
// Keyboard interrupt detector with latched flag and acknowledge.
`timescale 1ns/1ps
module key_irq_unit (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Controls.
  input wire logic [gpio_pkg::PORT_W-1:0] i_pins,
  input wire logic [gpio_pkg::PORT_W-1:0] i_en,
  input wire logic [gpio_pkg::PORT_W-1:0] i_pol,
  input wire logic i_mode,
  input wire logic i_ack,
  // Status.
  output logic o_flag
);
  import gpio_pkg::*;
  logic [PORT_W-1:0] asserted;
  logic [PORT_W-1:0] prev_r;
  logic [PORT_W-1:0] prev_nxt;
  logic flag_r;
  logic flag_nxt;
  logic edge_hit;
  logic level_hit;

  always_comb begin
    asserted = i_en & ~(i_pins ^ i_pol); // R18 R20
    edge_hit = |(asserted & ~prev_r); // R21 R22
    level_hit = i_mode & (|asserted); // R19 R25
    prev_nxt = asserted;
    // A new event beats a simultaneous acknowledge.
    flag_nxt = edge_hit | level_hit | (flag_r & ~i_ack); // R23 R24 R25
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      prev_r <= PORT_RST;
      flag_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign o_flag = flag_r;

  a_edge_sets_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R21
    edge_hit |=> flag_r) else $error("Edge did not set the key flag.");
  a_ack_clears_edge: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R24
    (i_ack && !i_mode && !edge_hit) |=> !flag_r) else $error("Acknowledge did not clear flag.");
  a_level_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R25
    (i_ack && i_mode && (|asserted)) |=> flag_r) else $error("Level flag cleared early.");
  c_key_edge: cover property (@(posedge i_clk) disable iff (!i_rst_n) edge_hit ##1 flag_r);
endmodule : key_irq_unit

// [logic/gpio_port.sv]
// General-purpose port with register slave, pin control and key interrupt.
// Behaviour
// R1: Reset makes all pins inputs and clears pull, slew and drive bits.
// R2: An enabled shared peripheral overrides the port function of its pin.
// R3: Direction bit enables the driver and picks the data read source.
// R4: Input pins read the pad level; output pins read the latch.
// R5: Input buffer stays on unless analog or output-only.
// R6: Shared digital function drives the pin; direction still picks read source.
// R7: Analog disables both buffers; input data reads return zero.
// R8: Analog beats an alternate digital function on the same pin.
// R9: Software should load the latch before turning a pin to output.
// R10: Pull-up follows its bit but is off when driven or analog.
// R11: Slew limiting only acts on driven pins.
// R12: Drive select chooses high drive for a driven pin.
// R13: Pull, slew and drive controls are independent and serve peripherals too.
// R14: Set writes OR the pattern into the latch.
// R15: Clear writes clear latch bits where the pattern is one.
// R16: Toggle writes invert latch bits where the pattern is one.
// R17: Set, clear and toggle finish within one bus write.
// R18: Each key input has an enable; only enabled inputs are detected.
// R19: Mode bit picks edge-only or edge-and-level detection.
// R20: Per-pin polarity picks falling/low or rising/high sensitivity.
// R21: Falling edge is high then low over two bus cycles.
// R22: Rising edge is low then high over two bus cycles.
// R23: A valid edge sets the flag; with enable, an interrupt request follows.
// R24: In edge-only mode, acknowledge clears the flag.
// R25: In edge-and-level mode, acknowledge keeps the flag while a pin is asserted.
// R26: Key polarity zero selects pull-up, one selects pull-down; here a pin gets pull-down only when its key enable is also set.
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module gpio_port #(
  parameter bit HAS_SCT = 1'b1,
  parameter logic [gpio_pkg::PORT_W-1:0] OUT_ONLY = 8'h00
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave.
  input wire logic [gpio_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [gpio_pkg::DATA_W-1:0] i_avs_writedata,
  output logic [gpio_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Pads.
  input wire logic [gpio_pkg::PORT_W-1:0] i_pin,
  output gpio_pkg::pin_ctrl_t o_pin_ctrl,
  // Shared on-chip functions.
  input wire gpio_pkg::alt_req_t i_alt,
  input wire logic [gpio_pkg::PORT_W-1:0] i_analog,
  output logic [gpio_pkg::PORT_W-1:0] o_alt_in,
  // Key interrupt request.
  output logic o_key_irq
);
  import gpio_pkg::*;

  logic [PORT_W-1:0] latch_r;
  logic [PORT_W-1:0] latch_nxt;
  logic [PORT_W-1:0] dir_r;
  logic [PORT_W-1:0] dir_nxt;
  logic [PORT_W-1:0] pull_r;
  logic [PORT_W-1:0] pull_nxt;
  logic [PORT_W-1:0] slew_r;
  logic [PORT_W-1:0] slew_nxt;
  logic [PORT_W-1:0] drive_r;
  logic [PORT_W-1:0] drive_nxt;
  logic [PORT_W-1:0] key_en_r;
  logic [PORT_W-1:0] key_en_nxt;
  logic [PORT_W-1:0] key_pol_r;
  logic [PORT_W-1:0] key_pol_nxt;
  logic key_mode_r;
  logic key_mode_nxt;
  logic key_ie_r;
  logic key_ie_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic req;
  logic taken;
  logic wr_taken;
  logic key_ack;
  logic key_flag;
  logic [PORT_W-1:0] wpat;
  logic [PORT_W-1:0] port_rd;
  logic [PORT_W-1:0] seen;

  // Widens a port-wide value into a bus word with zero upper bits.
  function automatic logic [DATA_W-1:0] widen(input logic [PORT_W-1:0] v);
    widen = {{(DATA_W-PORT_W){1'b0}}, v};
  endfunction : widen

  // True when the given address equals the given offset.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  gpio_pin_mux #(
    .OUT_ONLY(OUT_ONLY)
  ) u_mux (
    .i_latch(latch_r),
    .i_dir(dir_r),
    .i_pull_en(pull_r),
    .i_slew_en(slew_r),
    .i_drive_sel(drive_r),
    .i_key_en(key_en_r),
    .i_key_pol(key_pol_r),
    .i_alt(i_alt),
    .i_analog(i_analog),
    .i_pin(i_pin),
    .o_ctrl(o_pin_ctrl),
    .o_seen(seen),
    .o_rd(port_rd)
  );

  key_irq_unit u_key (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pins(seen),
    .i_en(key_en_r),
    .i_pol(key_pol_r),
    .i_mode(key_mode_r),
    .i_ack(key_ack),
    .o_flag(key_flag)
  );

  // Every access waits one cycle; the second cycle completes it.
  always_comb begin
    req = i_avs_read | i_avs_write;
    taken = req & ack_r;
    wr_taken = i_avs_write & ack_r;
    ack_nxt = req & ~ack_r;
    wpat = i_avs_writedata[PORT_W-1:0];
    key_ack = wr_taken & hit(i_avs_address, OFF_KEY_SC) & i_avs_writedata[KSC_ACK_BIT]; // R24
  end

  always_comb begin
    latch_nxt = latch_r;
    dir_nxt = dir_r;
    pull_nxt = pull_r;
    slew_nxt = slew_r;
    drive_nxt = drive_r;
    key_en_nxt = key_en_r;
    key_pol_nxt = key_pol_r;
    key_mode_nxt = key_mode_r;
    key_ie_nxt = key_ie_r;
    if (wr_taken) begin
      case (i_avs_address)
        OFF_DATA: latch_nxt = wpat;
        OFF_DIR: dir_nxt = wpat; // R3
        OFF_PULL: pull_nxt = wpat; // R13
        OFF_SLEW: slew_nxt = wpat; // R13
        OFF_DRIVE: drive_nxt = wpat; // R13
        OFF_SET: latch_nxt = HAS_SCT ? (latch_r | wpat) : latch_r; // R14 R17
        OFF_CLR: latch_nxt = HAS_SCT ? (latch_r & ~wpat) : latch_r; // R15 R17
        OFF_TOG: latch_nxt = HAS_SCT ? (latch_r ^ wpat) : latch_r; // R16 R17
        OFF_KEY_EN: key_en_nxt = wpat; // R18
        OFF_KEY_POL: key_pol_nxt = wpat; // R20
        OFF_KEY_SC: begin
          key_mode_nxt = i_avs_writedata[KSC_MODE_BIT]; // R19
          key_ie_nxt = i_avs_writedata[KSC_IE_BIT];
        end
        default: latch_nxt = latch_r;
      endcase
    end
  end

  // Read data are prepared in the wait cycle and stand at the completing edge.
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_avs_read && !ack_r) begin
      case (i_avs_address)
        OFF_DATA: rdata_nxt = widen(port_rd); // R4
        OFF_DIR: rdata_nxt = widen(dir_r);
        OFF_PULL: rdata_nxt = widen(pull_r);
        OFF_SLEW: rdata_nxt = widen(slew_r);
        OFF_DRIVE: rdata_nxt = widen(drive_r);
        OFF_KEY_EN: rdata_nxt = widen(key_en_r);
        OFF_KEY_POL: rdata_nxt = widen(key_pol_r);
        OFF_KEY_SC: begin
          rdata_nxt = RDATA_RST;
          rdata_nxt[KSC_MODE_BIT] = key_mode_r;
          rdata_nxt[KSC_IE_BIT] = key_ie_r;
          rdata_nxt[KSC_FLAG_BIT] = key_flag;
        end
        OFF_PINS: rdata_nxt = widen(seen);
        default: rdata_nxt = RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      latch_r <= PORT_RST;
      dir_r <= PORT_RST; // R1
      pull_r <= PORT_RST; // R1
      slew_r <= PORT_RST; // R1
      drive_r <= PORT_RST; // R1
      key_en_r <= PORT_RST;
      key_pol_r <= PORT_RST;
      key_mode_r <= 1'b0;
      key_ie_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= RDATA_RST;
    end else begin
      latch_r <= latch_nxt;
      dir_r <= dir_nxt;
      pull_r <= pull_nxt;
      slew_r <= slew_nxt;
      drive_r <= drive_nxt;
      key_en_r <= key_en_nxt;
      key_pol_r <= key_pol_nxt;
      key_mode_r <= key_mode_nxt;
      key_ie_r <= key_ie_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_avs_waitrequest = req & ~ack_r;
  assign o_avs_readdata = rdata_r;
  assign o_alt_in = seen;
  assign o_key_irq = key_flag & key_ie_r; // R23

  a_reset_defaults: assert property (@(posedge i_clk) // R1
    !i_rst_n |=> (dir_r == PORT_RST && pull_r == PORT_RST
      && slew_r == PORT_RST && drive_r == PORT_RST))
    else $error("Pin controls not cleared by reset.");
  a_dir_drives_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
    ((o_pin_ctrl.oe ^ dir_r) & ~i_alt.en & ~i_analog) == PORT_RST)
    else $error("Driver does not follow direction.");
  a_alt_owns_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
    ((o_pin_ctrl.oe ^ i_alt.oe) & i_alt.en & ~i_analog) == PORT_RST)
    else $error("Shared function does not own the driver.");
  a_analog_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
    (i_analog & (o_pin_ctrl.oe | o_pin_ctrl.ibuf)) == PORT_RST)
    else $error("Analog pin has a buffer enabled.");
  a_pull_released: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
    ((o_pin_ctrl.pull_up | o_pin_ctrl.pull_down) & (o_pin_ctrl.oe | i_analog)) == PORT_RST)
    else $error("Pull active on a driven or analog pin.");
  a_slew_outputs: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
    (o_pin_ctrl.slew & ~o_pin_ctrl.oe) == PORT_RST)
    else $error("Slew limit on an input pin.");
  a_data_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
    (i_avs_read && !ack_r && i_avs_address == OFF_DATA) |=> o_avs_readdata == widen($past(port_rd)))
    else $error("Data read returned the wrong source.");
  a_set_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
    (wr_taken && i_avs_address == OFF_SET && HAS_SCT)
      |=> latch_r == ($past(latch_r) | $past(wpat)))
    else $error("Set write did not OR into the latch.");
  a_clear_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
    (wr_taken && i_avs_address == OFF_CLR && HAS_SCT)
      |=> latch_r == ($past(latch_r) & ~$past(wpat)))
    else $error("Clear write did not clear latch bits.");
  a_toggle_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R16
    (wr_taken && i_avs_address == OFF_TOG && HAS_SCT)
      |=> latch_r == ($past(latch_r) ^ $past(wpat)))
    else $error("Toggle write did not invert latch bits.");
  a_one_cycle_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
    (req && !ack_r) |=> (ack_r && !o_avs_waitrequest) || !req)
    else $error("Access not completed after one wait cycle.");
  a_irq_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R23
    o_key_irq == (key_flag && key_ie_r))
    else $error("Interrupt request does not follow flag and enable.");

  // Steering of the pad controls, checked pin by pin against the registers and the shared and analog inputs.
  a_alt_drives_out: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
    ((o_pin_ctrl.out ^ i_alt.out) & o_pin_ctrl.oe & i_alt.en & ~i_analog) == PORT_RST)
    else $error("Shared function does not drive the pin level.");
  a_ibuf_enabled: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5
    (~o_pin_ctrl.ibuf & ~i_analog & ~OUT_ONLY) == PORT_RST)
    else $error("Input buffer off on a digital pin.");
  a_analog_beats_alt: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
    (i_analog & i_alt.en & (o_pin_ctrl.oe | o_pin_ctrl.ibuf)) == PORT_RST)
    else $error("Shared digital function kept an analog pin.");
  a_pull_follows_bit: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
    ((o_pin_ctrl.pull_up | o_pin_ctrl.pull_down) ^ (pull_r & ~o_pin_ctrl.oe & ~i_analog))
      == PORT_RST)
    else $error("Pull does not follow its enable bit.");
  a_slew_follows_bit: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11 R13
    (o_pin_ctrl.slew ^ (slew_r & o_pin_ctrl.oe)) == PORT_RST)
    else $error("Slew limit does not follow its bit.");
  a_drive_follows_bit: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R12
    (o_pin_ctrl.high_drive ^ (drive_r & o_pin_ctrl.oe)) == PORT_RST)
    else $error("Drive select does not follow its bit.");
  a_pull_down_key: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R26
    (o_pin_ctrl.pull_down & ~(key_en_r & key_pol_r)) == PORT_RST)
    else $error("Pull-down on a pin without key polarity one.");

  // Read source of the data register.
  a_output_reads_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
    ((port_rd ^ latch_r) & dir_r) == PORT_RST)
    else $error("Output pin does not read the latch.");
  a_input_reads_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
    ((port_rd ^ seen) & ~dir_r) == PORT_RST)
    else $error("Input pin does not read the pad level.");
  a_analog_reads_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
    (port_rd & i_analog & ~dir_r) == PORT_RST)
    else $error("Analog input pin does not read zero.");

  // Register writes land at the completing edge only.
  a_taken_once: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
    taken |=> !taken)
    else $error("Access completed twice in a row.");
  a_data_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
    (wr_taken && i_avs_address == OFF_DATA) |=> latch_r == $past(wpat))
    else $error("Data write did not reach the latch.");
  a_dir_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
    (wr_taken && i_avs_address == OFF_DIR) |=> dir_r == $past(wpat))
    else $error("Direction write did not land.");
  a_pull_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
    (wr_taken && i_avs_address == OFF_PULL) |=> pull_r == $past(wpat))
    else $error("Pull write did not land.");
  a_drive_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
    (wr_taken && i_avs_address == OFF_DRIVE) |=> drive_r == $past(wpat))
    else $error("Drive write did not land.");
  a_key_en_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R18
    (wr_taken && i_avs_address == OFF_KEY_EN) |=> key_en_r == $past(wpat))
    else $error("Key enable write did not land.");
  a_key_pol_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R20
    (wr_taken && i_avs_address == OFF_KEY_POL) |=> key_pol_r == $past(wpat))
    else $error("Key polarity write did not land.");
  a_mode_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R19
    (wr_taken && i_avs_address == OFF_KEY_SC)
      |=> key_mode_r == $past(i_avs_writedata[KSC_MODE_BIT]))
    else $error("Key mode write did not land.");
  a_ie_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R23
    (wr_taken && i_avs_address == OFF_KEY_SC)
      |=> key_ie_r == $past(i_avs_writedata[KSC_IE_BIT]))
    else $error("Key request enable write did not land.");
  a_sct_reads_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
    (i_avs_read && !ack_r && i_avs_address == OFF_SET) |=> o_avs_readdata == RDATA_RST)
    else $error("Write-only set register did not read zero.");
  a_readdata_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
    !(i_avs_read && !ack_r) |=> $stable(o_avs_readdata))
    else $error("Read data changed outside a read.");

  c_set_write: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_taken && i_avs_address == OFF_SET);
  c_key_irq: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_key_irq ##1 o_key_irq);
  c_ack_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    key_ack ##1 !key_flag);
  c_alt_pin: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    |(i_alt.en & i_alt.oe & ~i_analog));
endmodule : gpio_port

// [testbench/pad_model.sv]
// Pad and external driver model that resolves the level of each port pin.
`timescale 1ns/1ps
module pad_model (
  // Clock.
  input wire logic i_clk,
  // Pad controls and external drive.
  input wire gpio_pkg::pin_ctrl_t i_ctrl,
  input wire logic [gpio_pkg::PORT_W-1:0] i_ext,
  input wire logic [gpio_pkg::PORT_W-1:0] i_ext_en,
  // Resolved pad level.
  output logic [gpio_pkg::PORT_W-1:0] o_pin
);
  import gpio_pkg::*;
  logic [PORT_W-1:0] float_r = 8'h00;
  // An undriven pad with no pull wanders, so it shows the inverse of its last level.
  always_ff @(posedge i_clk) begin
    float_r <= ~o_pin;
  end
  assign o_pin = (i_ctrl.oe & i_ctrl.out) | (~i_ctrl.oe & i_ext_en & i_ext) |
    (~i_ctrl.oe & ~i_ext_en & (i_ctrl.pull_up | (~i_ctrl.pull_down & float_r)));
endmodule : pad_model

// [testbench/gpio_port_with_key_interrupt_tb.sv]
// Self-checking bench for the general-purpose port and its key interrupt.
`timescale 1ns/1ps
module gpio_port_with_key_interrupt_tb;
  import gpio_pkg::*;
  localparam logic [7:0] IE_M = 8'h01 << KSC_IE_BIT;
  localparam logic [7:0] ACK_M = 8'h01 << KSC_ACK_BIT;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [ADDR_W-1:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [DATA_W-1:0] wd = 32'h0;
  logic [DATA_W-1:0] rdata;
  logic wreq;
  logic irq;
  logic [PORT_W-1:0] pin;
  logic [PORT_W-1:0] alt_in;
  logic [PORT_W-1:0] ext = 8'h00;
  logic [PORT_W-1:0] ext_en = 8'h00;
  logic [PORT_W-1:0] ana = 8'h00;
  alt_req_t alt = '0;
  pin_ctrl_t ctrl;
  int miscompares = 0;
  int n_checks = 0;
  logic [DATA_W-1:0] q;
  logic [PORT_W-1:0] dir, lat, pul, slw, drv, ken, kpol, oe, pa, pat;
  int op;

  gpio_port #(.HAS_SCT(1'b1), .OUT_ONLY(8'h00)) gpio_port_i (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_pin(pin),
    .o_pin_ctrl(ctrl), .i_alt(alt), .i_analog(ana), .o_alt_in(alt_in), .o_key_irq(irq));
  pad_model pad_model_i (.i_clk(i_clk), .i_ctrl(ctrl), .i_ext(ext), .i_ext_en(ext_en),
    .o_pin(pin));

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= {24'h0, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) begin
      miscompares++;
      complete_run();
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, exp});
  endtask : rdchk

  task automatic do_reset();
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(ctrl.oe | ctrl.pull_up | ctrl.pull_down | ctrl.slew | ctrl.high_drive, 0);
    chk(irq, 0);
    chk(ctrl.ibuf, {~ana});
    rdchk(OFF_DIR, 8'h00);
    rdchk(OFF_PULL, 8'h00);
    rdchk(OFF_SLEW, 8'h00);
    rdchk(OFF_DRIVE, 8'h00);
  endtask : do_reset

  task automatic flag(input logic exp);
    bus(1'b0, OFF_KEY_SC, 8'h00);
    chk(q[KSC_FLAG_BIT], exp);
  endtask : flag

  // Bit 0 is the only enabled key input; bit 1 is asserted while disabled.
  task automatic key(input logic mode, input logic pol);
    logic [7:0] md;
    md = {7'h0, mode} << KSC_MODE_BIT;
    bus(1'b1, OFF_KEY_SC, md);
    bus(1'b1, OFF_KEY_POL, {8{pol}});
    @(posedge i_clk);
    ext <= {8{~pol}};
    bus(1'b1, OFF_KEY_EN, 8'h01);
    bus(1'b1, OFF_KEY_SC, md | IE_M | ACK_M);
    @(posedge i_clk);
    ext <= {{6{~pol}}, pol, ~pol};
    repeat (3) @(posedge i_clk);
    flag(1'b0);
    @(posedge i_clk);
    ext <= {{6{~pol}}, pol, pol};
    repeat (3) @(posedge i_clk);
    chk(irq, 1);
    flag(1'b1);
    bus(1'b1, OFF_KEY_SC, md);
    @(posedge i_clk);
    chk(irq, 0);
    bus(1'b1, OFF_KEY_SC, md | ACK_M);
    flag(mode);
    @(posedge i_clk);
    ext <= {8{~pol}};
    repeat (3) @(posedge i_clk);
    bus(1'b1, OFF_KEY_SC, md | ACK_M);
    flag(1'b0);
  endtask : key

  initial begin
    #2500000;
    miscompares++;
    complete_run();
  end

  initial begin
    void'($urandom(32'hd3b2));
    do_reset();
    for (int i = 0; i < 40; i++) begin
      {dir, lat, pul, slw} = $urandom;
      {drv, ken, kpol} = 24'($urandom);
      @(posedge i_clk);
      ana <= 8'($urandom & $urandom);
      alt <= 24'($urandom);
      ext <= 8'($urandom);
      ext_en <= 8'hFF;
      bus(1'b1, OFF_DATA, lat);
      bus(1'b1, OFF_DIR, dir);
      bus(1'b1, OFF_PULL, pul);
      bus(1'b1, OFF_SLEW, slw);
      bus(1'b1, OFF_DRIVE, drv);
      bus(1'b1, OFF_KEY_EN, ken);
      bus(1'b1, OFF_KEY_POL, kpol);
      rdchk(OFF_DATA, (dir & lat) | (~dir & pin & ~ana));
      rdchk(OFF_DIR, dir);
      rdchk(OFF_SLEW, slw);
      rdchk(OFF_PULL, pul);
      rdchk(OFF_DRIVE, drv);
      rdchk(OFF_PINS, pin & ~ana);
      oe = ((alt.en & alt.oe) | (~alt.en & dir)) & ~ana;
      pa = pul & ~oe & ~ana;
      chk(ctrl.oe, oe);
      chk(ctrl.out & oe, ((alt.en & alt.out) | (~alt.en & lat)) & oe);
      chk(ctrl.ibuf, {~ana});
      chk(alt_in, pin & ~ana);
      chk(ctrl.pull_up, pa & ~(ken & kpol));
      chk(ctrl.pull_down, pa & ken & kpol);
      chk(ctrl.slew, slw & oe);
      chk(ctrl.high_drive, drv & oe);
    end
    @(posedge i_clk);
    ana <= 8'h00;
    alt <= '0;
    do_reset();
    bus(1'b1, 6'h30, 8'hFF);
    rdchk(6'h30, 8'h00);
    rdchk(OFF_SET, 8'h00);
    lat = 8'($urandom);
    bus(1'b1, OFF_DATA, lat);
    bus(1'b1, OFF_DIR, 8'hFF);
    for (int i = 0; i < 24; i++) begin
      op = i % 3;
      pat = 8'($urandom);
      bus(1'b1, OFF_SET + 6'(4 * op), pat);
      lat = (op == 0) ? (lat | pat) : (op == 1) ? (lat & ~pat) : (lat ^ pat);
      rdchk(OFF_DATA, lat);
      chk(ctrl.out, lat);
    end
    bus(1'b1, OFF_DIR, 8'h00);
    key(1'b0, 1'b0);
    key(1'b0, 1'b1);
    key(1'b1, 1'b0);
    key(1'b1, 1'b1);
    complete_run();
  end
endmodule : gpio_port_with_key_interrupt_tb
